// ---- src/isd_pkg.sv ----
package isd_pkg;

    // System clock rate, used to turn times into cycle counts
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;

    // Shoot-through dead time added after the monitor input falls (least)
    localparam int STP_DEAD_NS = 200;
    localparam int STP_DEAD_CYC = (STP_DEAD_NS * CLK_MHZ + 999) / 1000;

    // Blanking after turn-on before desaturation_in, overcurrent and gate are judged
    localparam int BLANK_NS = 1000;
    localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;

    // Delay from end of reset until the ready line is released (least)
    localparam int READY_NS = 2000;
    localparam int READY_CYC = (READY_NS * CLK_MHZ + 999) / 1000;

    // Time the start-stop oscillator keeps running after a turn-off
    localparam int TURNOFF_NS = 500;
    localparam int TURNOFF_CYC = (TURNOFF_NS * CLK_MHZ + 999) / 1000;

    // Oscillator monitor: rising edges counted per window of clk_sys
    localparam int OSC_WINDOW_CYC = 256;
    localparam int OSC_MIN_EDGES = 24;
    localparam int OSC_MAX_EDGES = 40;

    // Bit positions of the primary-side synchroniser vector
    localparam int PRI_PWM = 0;
    localparam int PRI_STM = 1;
    localparam int PRI_EN = 2;
    localparam int PRI_CSN = 3;
    localparam int PRI_RSTN = 4;
    localparam int PRI_W = 5;
    // Pull-device levels: select and reset pins idle high, others low
    localparam logic [PRI_W-1:0] PRI_INIT = 5'h18;

    // Bit positions of the secondary-side synchroniser vector
    localparam int SEC_DESATURATION_IN = 0;
    localparam int SEC_OCP = 1;
    localparam int SEC_GATE = 2;
    localparam int SEC_OSD = 3;
    localparam int SEC_DBG = 4;
    localparam int SEC_VCC2 = 5;
    localparam int SEC_VREG = 6;
    localparam int SEC_W = 7;
    // Desaturation_in and overcurrent idle high; supplies start as not valid
    localparam logic [SEC_W-1:0] SEC_INIT = 7'h03;

    // Open-drain pins only ever drive this level
    localparam logic OD_LOW = 1'b0;

    // Output stage sequence, Gray coded along the usual path
    typedef enum logic [1:0] {
        STG_IDLE = 2'h0,
        STG_ON = 2'h1,
        STG_TURNOFF = 2'h3,
        STG_STOP = 2'h2
    } isd_stage_e;

endpackage

// ---- src/isd_sync.sv ----
module isd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Pin levels in, synchronised levels out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1Reg;
    logic [WIDTH-1:0] stage2Reg;

    // Two-flop chain; reset to the level the pin's pull device gives
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            stage1Reg <= INIT;
            stage2Reg <= INIT;
        end
        else
        begin
            stage1Reg <= asyncIn;
            stage2Reg <= stage1Reg;
        end
    end

    assign syncOut = stage2Reg;

endmodule

// ---- src/isd_osc_monitor.sv ----
module isd_osc_monitor #(
    parameter int WINDOW = isd_pkg::OSC_WINDOW_CYC,
    parameter int MIN_EDGES = isd_pkg::OSC_MIN_EDGES,
    parameter int MAX_EDGES = isd_pkg::OSC_MAX_EDGES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Synchronised oscillator level and verdict
    input wire logic oscLevel,
    output logic oscFail
);

    localparam int WW = $clog2(WINDOW + 1);
    localparam int EW = $clog2(MAX_EDGES + 2);
    localparam logic [WW-1:0] WIN_LAST = WW'(WINDOW - 1);
    localparam logic [EW-1:0] E_MIN = EW'(MIN_EDGES);
    localparam logic [EW-1:0] E_MAX = EW'(MAX_EDGES);
    localparam logic [EW-1:0] E_SAT = EW'(MAX_EDGES + 1);

    logic prevReg;
    logic [WW-1:0] winCntReg;
    logic [EW-1:0] edgeCntReg;
    logic oscFailReg;
    logic rise;

    assign rise = oscLevel && !prevReg;

    // Count edges per window; saturate so a fast clock cannot wrap
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            prevReg <= 1'b0;
            winCntReg <= '0;
            edgeCntReg <= '0;
            oscFailReg <= 1'b0;
        end
        else
        begin
            prevReg <= oscLevel;
            if (winCntReg == WIN_LAST)
            begin
                winCntReg <= '0;
                edgeCntReg <= '0;
                if (edgeCntReg < E_MIN || edgeCntReg > E_MAX)
                    oscFailReg <= 1'b1; // Too slow, too fast or stuck
                else
                    oscFailReg <= 1'b0;
            end
            else
            begin
                winCntReg <= winCntReg + WW'(1);
                if (rise && edgeCntReg != E_SAT)
                    edgeCntReg <= edgeCntReg + EW'(1);
            end
        end
    end

    assign oscFail = oscFailReg;

endmodule

// ---- src/isd_pin_control.sv ----
module isd_pin_control (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Primary side control inputs
    input wire logic pwmIn,
    input wire logic shootThroughMonitorIn,
    input wire logic enableIn,
    input wire logic chipSelectN,
    // Primary side reset and ready pin, open drain
    input wire logic resetNReadyIn,
    output logic resetNReadyOut,
    output logic resetNReadyOe,
    // Primary side fault pins, open drain
    output logic faultClassANOut,
    output logic faultClassANOe,
    output logic faultClassBNOut,
    output logic faultClassBNOe,
    // Serial interface state
    output logic serialSelected,
    // Secondary side monitor inputs
    input wire logic desaturationIn,
    input wire logic overcurrentIn,
    input wire logic gateMonitorIn,
    input wire logic outputStageDisable,
    input wire logic debugStrap,
    input wire logic vcc2Valid,
    input wire logic digitalSupplyValid,
    // Secondary side gate and booster outputs
    output logic turnOnOut,
    output logic turnOnOe,
    output logic turnOffOut,
    output logic turnOffOe,
    output logic clampDisableOut,
    output logic secondarySupplyInvalidNOut,
    output logic secondarySupplyInvalidNOe,
    output logic debugMode,
    // Oscillators
    input wire logic primaryRcOsc,
    input wire logic secondaryRcOsc,
    output logic outputStageStartstopOsc
);

    localparam int SW = $clog2(isd_pkg::STP_DEAD_CYC + 1);
    localparam int BW = $clog2(isd_pkg::BLANK_CYC + 1);
    localparam int RW = $clog2(isd_pkg::READY_CYC + 1);
    localparam int TW = $clog2(isd_pkg::TURNOFF_CYC + 1);
    localparam logic [SW-1:0] DEAD_LOAD = SW'(isd_pkg::STP_DEAD_CYC);
    localparam logic [BW-1:0] BLANK_END = BW'(isd_pkg::BLANK_CYC);
    localparam logic [RW-1:0] READY_END = RW'(isd_pkg::READY_CYC);
    localparam logic [TW-1:0] OFF_END = TW'(isd_pkg::TURNOFF_CYC);

    logic [isd_pkg::PRI_W-1:0] priSync;
    logic [isd_pkg::SEC_W-1:0] secSync;
    logic [1:0] oscSync;
    logic priOscFail;
    logic secOscFail;
    logic pinReset;
    logic logicRst;
    logic readyReg;
    logic [1:0] readyDlyReg;
    logic [RW-1:0] readyCntReg;
    logic debugCapturedReg;
    logic debugModeReg;
    logic [SW-1:0] inhibitCntReg;
    logic inhibitAct;
    logic pwmPrevReg;
    logic pwmRise;
    logic pwmCmdReg;
    logic stpErrorReg;
    logic pwmChannelReg;
    logic configChannelReg;
    logic [1:0] statusChannelReg;
    isd_pkg::isd_stage_e stageReg;
    isd_pkg::isd_stage_e stageNext;
    logic [BW-1:0] onCntReg;
    logic [TW-1:0] offCntReg;
    logic blanked;
    logic secAEvent;
    logic secBEvent;
    logic supplyInvalidReg;
    logic faultAReg;
    logic faultBReg;
    logic turnOnReg;
    logic clampDisableReg;
    logic oscRunReg;
    logic selectedReg;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers; reset values mirror the pull devices

    isd_sync #(.WIDTH(isd_pkg::PRI_W), .INIT(isd_pkg::PRI_INIT)) u_priSync (
        .clk_sys(clk_sys),
        .rst(rst),
        .asyncIn({resetNReadyIn, chipSelectN, enableIn,
                  shootThroughMonitorIn, pwmIn}),
        .syncOut(priSync)
    );

    isd_sync #(.WIDTH(isd_pkg::SEC_W), .INIT(isd_pkg::SEC_INIT)) u_secSync (
        .clk_sys(clk_sys),
        .rst(rst),
        .asyncIn({digitalSupplyValid, vcc2Valid, debugStrap,
                  outputStageDisable, gateMonitorIn, overcurrentIn,
                  desaturationIn}),
        .syncOut(secSync)
    );

    // RC oscillators arrive as levels and are judged against clk_sys
    isd_sync #(.WIDTH(2), .INIT(2'h0)) u_oscSync (
        .clk_sys(clk_sys),
        .rst(rst),
        .asyncIn({secondaryRcOsc, primaryRcOsc}),
        .syncOut(oscSync)
    );

    isd_osc_monitor u_priOscMon (
        .clk_sys(clk_sys),
        .rst(rst),
        .oscLevel(oscSync[0]),
        .oscFail(priOscFail)
    );

    isd_osc_monitor u_secOscMon (
        .clk_sys(clk_sys),
        .rst(rst),
        .oscLevel(oscSync[1]),
        .oscFail(secOscFail)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reset pin and ready indication

    // Own low drive is ignored, else not-ready would reset itself forever;
    // delayed ready covers the pin's trip through the synchroniser
    assign pinReset = readyReg && readyDlyReg[1]
                      && !priSync[isd_pkg::PRI_RSTN];

    // Ready as seen two edges later, matching the pin synchroniser
    always_ff @(posedge clk_sys)
    begin
        if (logicRst)
            readyDlyReg <= 2'h0;
        else
            readyDlyReg <= {readyDlyReg[0], readyReg};
    end
    assign logicRst = rst || pinReset;

    // Ready released after a settling delay, withdrawn on primary oscillator failure
    always_ff @(posedge clk_sys)
    begin
        if (logicRst)
        begin
            readyCntReg <= '0;
            readyReg <= 1'b0;
        end
        else if (priOscFail)
        begin
            readyReg <= 1'b0;
        end
        else if (readyCntReg != READY_END)
        begin
            readyCntReg <= readyCntReg + RW'(1);
        end
        else
        begin
            readyReg <= 1'b1;
        end
    end

    // Strap caught once after power-up only; the pin reset keeps it
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            debugCapturedReg <= 1'b0;
            debugModeReg <= 1'b0;
        end
        else if (!debugCapturedReg && readyReg)
        begin
            debugCapturedReg <= 1'b1;
            debugModeReg <= secSync[isd_pkg::SEC_DBG];
        end
    end

    // Serial interface is live only while selected and not in debug mode
    always_ff @(posedge clk_sys)
    begin
        if (logicRst)
            selectedReg <= 1'b0;
        else
            selectedReg <= !priSync[isd_pkg::PRI_CSN]
                           && !debugModeReg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Primary PWM input stage

    // Inhibit lasts while the monitor is high plus the dead time
    always_ff @(posedge clk_sys)
    begin
        if (logicRst)
            inhibitCntReg <= '0;
        else if (priSync[isd_pkg::PRI_STM])
            inhibitCntReg <= DEAD_LOAD;
        else if (inhibitCntReg != '0)
            inhibitCntReg <= inhibitCntReg - SW'(1);
    end

    assign inhibitAct = priSync[isd_pkg::PRI_STM] || inhibitCntReg != '0;
    assign pwmRise = priSync[isd_pkg::PRI_PWM] && !pwmPrevReg;

    // Only a rising edge turns on, so an inhibited edge stays lost
    always_ff @(posedge clk_sys)
    begin
        if (logicRst)
        begin
            pwmPrevReg <= 1'b0;
            pwmCmdReg <= 1'b0;
            stpErrorReg <= 1'b0;
        end
        else
        begin
            pwmPrevReg <= priSync[isd_pkg::PRI_PWM];
            stpErrorReg <= pwmRise && inhibitAct
                           && priSync[isd_pkg::PRI_EN];
            if (!priSync[isd_pkg::PRI_PWM] || !priSync[isd_pkg::PRI_EN]
                || faultAReg)
                pwmCmdReg <= 1'b0;
            else if (pwmRise && !inhibitAct)
                pwmCmdReg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels across the isolation barrier

    // PWM has its own one-way path; status and config share the other
    always_ff @(posedge clk_sys)
    begin
        if (logicRst)
        begin
            pwmChannelReg <= 1'b0;
            configChannelReg <= 1'b0;
            statusChannelReg <= 2'h0;
        end
        else
        begin
            pwmChannelReg <= pwmCmdReg;
            configChannelReg <= priSync[isd_pkg::PRI_EN];
            statusChannelReg <= {secBEvent, secAEvent};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Secondary output stage

    assign blanked = onCntReg == BLANK_END;
    // Desaturation_in and overcurrent judged once turn-on blanking has passed
    assign secAEvent = stageReg == isd_pkg::STG_ON && blanked
                       && (secSync[isd_pkg::SEC_DESATURATION_IN]
                           || secSync[isd_pkg::SEC_OCP]);
    // Gate disagreeing with the commanded state, or a dead oscillator
    assign secBEvent = secOscFail
                       || (stageReg == isd_pkg::STG_ON && blanked
                           && !secSync[isd_pkg::SEC_GATE])
                       || (stageReg == isd_pkg::STG_IDLE
                           && secSync[isd_pkg::SEC_GATE]);

    // Stage sequence; any stop reason leads through a timed turn-off
    always_comb
    begin
        stageNext = stageReg;
        case (stageReg)
            isd_pkg::STG_IDLE:
                if (pwmChannelReg && configChannelReg && !faultAReg
                    && !secSync[isd_pkg::SEC_OSD])
                    stageNext = isd_pkg::STG_ON;
            isd_pkg::STG_ON:
                if (!pwmChannelReg || !configChannelReg || secAEvent
                    || secSync[isd_pkg::SEC_OSD])
                    stageNext = isd_pkg::STG_TURNOFF;
            isd_pkg::STG_TURNOFF:
                if (offCntReg == OFF_END)
                    stageNext = isd_pkg::STG_STOP;
            default:
                stageNext = isd_pkg::STG_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (logicRst)
            stageReg <= isd_pkg::STG_IDLE;
        else
            stageReg <= stageNext;
    end

    // On-time counter for blanking, off-time counter for osc run-down
    always_ff @(posedge clk_sys)
    begin
        if (logicRst)
        begin
            onCntReg <= '0;
            offCntReg <= '0;
        end
        else
        begin
            if (stageReg != isd_pkg::STG_ON)
                onCntReg <= '0;
            else if (!blanked)
                onCntReg <= onCntReg + BW'(1);
            if (stageReg != isd_pkg::STG_TURNOFF)
                offCntReg <= '0;
            else if (offCntReg != OFF_END)
                offCntReg <= offCntReg + TW'(1);
        end
    end

    // Gate, clamp and oscillator drives come straight from flops
    always_ff @(posedge clk_sys)
    begin
        if (logicRst)
        begin
            turnOnReg <= 1'b0;
            clampDisableReg <= 1'b0;
            oscRunReg <= 1'b0;
        end
        else
        begin
            turnOnReg <= stageNext == isd_pkg::STG_ON;
            clampDisableReg <= stageNext == isd_pkg::STG_ON;
            oscRunReg <= stageNext == isd_pkg::STG_ON
                         || stageNext == isd_pkg::STG_TURNOFF;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Faults and supply flag

    // Faults are sticky until reset; nothing else clears them
    always_ff @(posedge clk_sys)
    begin
        if (logicRst)
        begin
            faultAReg <= 1'b0;
            faultBReg <= 1'b0;
            supplyInvalidReg <= 1'b1;
        end
        else
        begin
            if (statusChannelReg[0])
                faultAReg <= 1'b1;
            if (statusChannelReg[1] || priOscFail || stpErrorReg)
                faultBReg <= 1'b1;
            supplyInvalidReg <= !secSync[isd_pkg::SEC_VCC2]
                                || !secSync[isd_pkg::SEC_VREG];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drives

    assign resetNReadyOut = isd_pkg::OD_LOW;
    assign resetNReadyOe = !readyReg;
    assign faultClassANOut = isd_pkg::OD_LOW;
    assign faultClassANOe = faultAReg;
    assign faultClassBNOut = isd_pkg::OD_LOW;
    // Supply loss is reported as a level, not latched
    assign faultClassBNOe = faultBReg || supplyInvalidReg;
    assign secondarySupplyInvalidNOut = isd_pkg::OD_LOW;
    assign secondarySupplyInvalidNOe = supplyInvalidReg;
    assign turnOnOut = turnOnReg;
    assign turnOffOut = !turnOnReg;
    assign turnOnOe = !secSync[isd_pkg::SEC_OSD];
    assign turnOffOe = !secSync[isd_pkg::SEC_OSD];
    assign clampDisableOut = clampDisableReg;
    assign outputStageStartstopOsc = oscRunReg;
    assign debugMode = debugModeReg;
    assign serialSelected = selectedReg;

endmodule

// ---- bench/isd_booster_model.sv ----
module isd_booster_model (
    // Clock
    input wire logic clk_sys,
    // Gate drive from the block
    input wire logic turnOnOut,
    input wire logic turnOnOe,
    // Fault requests from the bench
    input wire logic desatCmd,
    input wire logic ocpCmd,
    // Sense lines back to the block
    output logic gateMonitorIn,
    output logic desaturationIn,
    output logic overcurrentIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // Gate follows the drive a cycle late; a tristated stage lets it sag
    initial gateMonitorIn = 1'h0;
    always @(posedge clk_sys)
    begin
        gateMonitorIn <= turnOnOut && turnOnOe;
    end

    // Sense lines only show a fault when a scenario asks for one
    assign desaturationIn = desatCmd;
    assign overcurrentIn = ocpCmd;
endmodule

// ---- bench/isd_pin_control_assertions.sv ----
module isd_pin_control_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Watched inputs
    input wire logic pwmIn,
    input wire logic enableIn,
    input wire logic resetNReadyIn,
    input wire logic outputStageDisable,
    input wire logic vcc2Valid,
    // Watched outputs
    input wire logic resetNReadyOut,
    input wire logic resetNReadyOe,
    input wire logic faultClassANOut,
    input wire logic faultClassANOe,
    input wire logic faultClassBNOe,
    input wire logic turnOnOut,
    input wire logic turnOnOe,
    input wire logic turnOffOut,
    input wire logic turnOffOe,
    input wire logic clampDisableOut,
    input wire logic secondarySupplyInvalidNOe,
    input wire logic outputStageStartstopOsc
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // A turn-on needs PWM and enable seen high well before the output
    sequence pwmLaunchSeq;
        $past(pwmIn, 3) && $past(enableIn, 3);
    endsequence
    sequence stageOffSeq;
        $rose(outputStageDisable);
    endsequence

    ////////////////////////////////////////////////////////////
    od_data_low_a: assert property (!resetNReadyOut && !faultClassANOut)
        else $error("open-drain data driven high");
    gate_pair_a: assert property (turnOffOut == !turnOnOut)
        else $error("turn-on and turn-off outputs agree");
    clamp_follow_a: assert property (clampDisableOut == turnOnOut)
        else $error("clamp disable not tied to gate on");
    osc_runs_a: assert property (turnOnOut |-> outputStageStartstopOsc)
        else $error("gate on without output-stage clock");
    pwm_launch_a: assert property ($rose(turnOnOut) |-> pwmLaunchSeq)
        else $error("turn-on without PWM and enable");
    pwm_release_a: assert property ((!pwmIn) [*8] |-> !turnOnOut)
        else $error("gate stays on after PWM low");
    enable_off_a: assert property ((!enableIn) [*8] |-> !turnOnOut)
        else $error("gate stays on while disabled");
    stage_tristate_a: assert property (stageOffSeq |->
        ##[1:3] (!turnOnOe && !turnOffOe))
        else $error("gate outputs not tristated");
    supply_flag_a: assert property ((!vcc2Valid) [*4] |->
        secondarySupplyInvalidNOe && faultClassBNOe)
        else $error("invalid supply not flagged");
    fault_hold_a: assert property ($past(faultClassANOe) && resetNReadyIn &&
        $past(resetNReadyIn) && $past(resetNReadyIn, 2) &&
        $past(resetNReadyIn, 3) |-> faultClassANOe)
        else $error("class A fault cleared without reset");
    ready_delay_a: assert property ($fell(rst) |-> resetNReadyOe [*8])
        else $error("ready released too early");
endmodule

bind isd_pin_control isd_pin_control_assertions chk (.clk_sys, .rst, .pwmIn,
    .enableIn, .resetNReadyIn, .outputStageDisable, .vcc2Valid, .resetNReadyOut,
    .resetNReadyOe, .faultClassANOut, .faultClassANOe, .faultClassBNOe,
    .turnOnOut, .turnOnOe, .turnOffOut, .turnOffOe, .clampDisableOut,
    .secondarySupplyInvalidNOe, .outputStageStartstopOsc);

// ---- bench/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // Bench-driven pins, all defined at time zero
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic pwmIn = 1'h0;
    logic shootThroughMonitorIn = 1'h0;
    logic enableIn = 1'h0;
    logic chipSelectN = 1'h1;
    logic tbPull = 1'h0;
    logic outputStageDisable = 1'h0;
    logic debugStrap = 1'h0;
    logic vcc2Valid = 1'h1;
    logic digitalSupplyValid = 1'h1;
    logic primaryRcOsc = 1'h0;
    logic secondaryRcOsc = 1'h0;
    logic oscHalt = 1'h0;
    logic desatCmd = 1'h0;
    logic ocpCmd = 1'h0;
    int seed = 51;
    int err_count = 0;
    int total_checks = 0;
    int n;
    logic en;
    wire logic resetNReadyIn, resetNReadyOut, resetNReadyOe, faultClassANOut;
    wire logic faultClassANOe, faultClassBNOut, faultClassBNOe, serialSelected;
    wire logic turnOnOut, turnOnOe, turnOffOut, turnOffOe, clampDisableOut;
    wire logic secondarySupplyInvalidNOut, secondarySupplyInvalidNOe;
    wire logic debugMode, outputStageStartstopOsc;
    wire logic gateMonitorIn, desaturationIn, overcurrentIn;

    // Pull-up wire: low if the block or the bench pulls it
    assign resetNReadyIn = !(resetNReadyOe || tbPull);

    isd_pin_control uut (.clk_sys, .rst, .pwmIn, .shootThroughMonitorIn,
        .enableIn, .chipSelectN, .resetNReadyIn, .resetNReadyOut,
        .resetNReadyOe, .faultClassANOut, .faultClassANOe, .faultClassBNOut,
        .faultClassBNOe, .serialSelected, .desaturationIn, .overcurrentIn,
        .gateMonitorIn, .outputStageDisable, .debugStrap, .vcc2Valid,
        .digitalSupplyValid, .turnOnOut, .turnOnOe, .turnOffOut, .turnOffOe,
        .clampDisableOut, .secondarySupplyInvalidNOut,
        .secondarySupplyInvalidNOe, .debugMode, .primaryRcOsc,
        .secondaryRcOsc, .outputStageStartstopOsc);
    isd_booster_model booster (.clk_sys, .turnOnOut, .turnOnOe, .desatCmd,
        .ocpCmd, .gateMonitorIn, .desaturationIn, .overcurrentIn);

    ////////////////////////////////////////////////////////////
    // Clocks; oscillators sit near 30 edges per monitor window
    initial forever #10 clk_sys = !clk_sys;
    initial #3 forever #85 primaryRcOsc = !primaryRcOsc;
    initial #3 forever #95 secondaryRcOsc = oscHalt ? 1'h0 : !secondaryRcOsc;

    // Supply flag expected whenever either supply is bad
    function automatic logic supplyBad(logic a, logic b);
        return !(a && b);
    endfunction

    task automatic tick(int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(string name, logic exp, logic got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic print_verdict;
        if (err_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Bounded wait; the count shows how late ready came
    task automatic waitReady;
        n = 0;
        while (resetNReadyOe !== 1'h0 && n < 2000)
        begin
            tick(1);
            n++;
        end
        chk("readyOe", 1'h0, resetNReadyOe);
    endtask

    task automatic doReset(logic strap);
        rst = 1'h1;
        debugStrap = strap;
        tick(5);
        chk("rstOn", 1'h0, turnOnOut);
        chk("rstOff", 1'h1, turnOffOut);
        chk("rstRdy", 1'h1, resetNReadyOe);
        chk("odLow", 1'h0, faultClassBNOut
            || secondarySupplyInvalidNOut);
        rst = 1'h0;
        waitReady();
        chk("readyLate", 1'h1, n >= isd_pkg::READY_CYC);
    endtask

    task automatic pinReset;
        tbPull = 1'h1;
        tick(4);
        chk("pinRstRdy", 1'h1, resetNReadyOe);
        tbPull = 1'h0;
        waitReady();
        chk("faultAClr", 1'h0, faultClassANOe);
        chk("faultBClr", 1'h0, faultClassBNOe);
    endtask

    // One PWM pulse; the gate answers five cycles after the pin rises
    task automatic pulse(int hi, logic exp);
        pwmIn = 1'h1;
        tick(6);
        chk("turnOn", exp, turnOnOut);
        chk("clamp", exp, clampDisableOut);
        chk("ssOsc", exp, outputStageStartstopOsc);
        tick(hi - 6);
        pwmIn = 1'h0;
        tick(8);
        chk("turnOff", 1'h0, turnOnOut);
        chk("offOut", 1'h1, turnOffOut);
        tick(40);
    endtask

    ////////////////////////////////////////////////////////////
    // Hang guard, sized well past the sequence below
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        err_count++;
        print_verdict();
    end

    initial
    begin
        doReset(1'h0);
        chk("faultB0", 1'h0, faultClassBNOe);
        // Random pulses, enable mostly on
        repeat (12)
        begin
            en = ($random(seed) & 3) != 0;
            enableIn = en;
            tick(4);
            pulse(10 + ($random(seed) & 31), en);
        end
        // Enable dropped while on
        enableIn = 1'h1;
        pwmIn = 1'h1;
        tick(8);
        enableIn = 1'h0;
        tick(8);
        chk("enOff", 1'h0, turnOnOut);
        pwmIn = 1'h0;
        enableIn = 1'h1;
        tick(40);
        // Stage disable while on
        pwmIn = 1'h1;
        tick(8);
        outputStageDisable = 1'h1;
        tick(3);
        chk("onOe", 1'h0, turnOnOe);
        chk("offOe", 1'h0, turnOffOe);
        outputStageDisable = 1'h0;
        pwmIn = 1'h0;
        tick(40);
        chk("oeBack", 1'h1, turnOnOe);
        pinReset();
        // Desaturation then overcurrent, each sticky until pin reset
        for (int f = 0; f < 2; f++)
        begin
            pwmIn = 1'h1;
            tick(8);
            desatCmd = (f == 0);
            ocpCmd = (f == 1);
            tick(70);
            chk("faultA", 1'h1, faultClassANOe);
            chk("faultOff", 1'h0, turnOnOut);
            pwmIn = 1'h0;
            desatCmd = 1'h0;
            ocpCmd = 1'h0;
            tick(40);
            chk("faultAHold", 1'h1, faultClassANOe);
            pinReset();
        end
        // Rising PWM edge during shoot-through inhibit
        shootThroughMonitorIn = 1'h1;
        tick(2);
        pwmIn = 1'h1;
        tick(8);
        chk("stpOn", 1'h0, turnOnOut);
        chk("stpFault", 1'h1, faultClassBNOe);
        pwmIn = 1'h0;
        shootThroughMonitorIn = 1'h0;
        tick(20);
        pinReset();
        // Each supply in turn
        for (int s = 0; s < 2; s++)
        begin
            vcc2Valid = (s != 0);
            digitalSupplyValid = (s == 0);
            tick(4);
            chk("supply", supplyBad(vcc2Valid, digitalSupplyValid),
                secondarySupplyInvalidNOe);
            chk("supplyB", 1'h1, faultClassBNOe);
            vcc2Valid = 1'h1;
            digitalSupplyValid = 1'h1;
            tick(4);
            chk("supplyOk", 1'h0, secondarySupplyInvalidNOe);
        end
        // Select active low
        chipSelectN = 1'h0;
        tick(4);
        chk("select", 1'h1, serialSelected);
        chipSelectN = 1'h1;
        tick(4);
        chk("deselect", 1'h0, serialSelected);
        // Stalled secondary oscillator
        oscHalt = 1'h1;
        tick(700);
        chk("oscFail", 1'h1, faultClassBNOe);
        oscHalt = 1'h0;
        // Strap high: debug mode, serial ignored, strap read once
        doReset(1'h1);
        tick(2);
        chk("debug", 1'h1, debugMode);
        debugStrap = 1'h0;
        chipSelectN = 1'h0;
        tick(4);
        chk("dbgSel", 1'h0, serialSelected);
        chk("dbgKeep", 1'h1, debugMode);
        print_verdict();
    end
endmodule
